// ---- rtl/led_current_pkg.sv ----
/*
 * Constants for the LED channel current register bank: register indices,
 * byte addresses, field positions and reset values.
 * Assumes a 32-bit APB bus with one aligned word per register.
 */
package led_current_pkg;

    // -------------------------------------------------------------------
    // Register indices and byte addresses
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W              = 8;
    localparam logic [7:0]  IDX_TRANSIENT_LIMIT = 8'h02;
    localparam logic [7:0]  IDX_CURRENT_HIGH    = 8'h03;
    localparam logic [7:0]  IDX_CURRENT_LOW     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TRANSIENT_LIMIT = ADDR_W'(IDX_TRANSIENT_LIMIT * 4);
    localparam logic [ADDR_W-1:0] ADDR_CURRENT_HIGH    = ADDR_W'(IDX_CURRENT_HIGH * 4);
    localparam logic [ADDR_W-1:0] ADDR_CURRENT_LOW     = ADDR_W'(IDX_CURRENT_LOW * 4);

    // -------------------------------------------------------------------
    // Field layout within each byte-wide register
    // -------------------------------------------------------------------
    localparam int unsigned LIMIT_CODE_LSB = 3;
    localparam int unsigned LIMIT_CODE_MSB = 6;
    localparam int unsigned THIRD_EN_BIT   = 2;
    localparam int unsigned SECOND_EN_BIT  = 1;
    localparam int unsigned FIRST_EN_BIT   = 0;
    localparam int unsigned CODE_HI_MSB    = 1;
    localparam int unsigned CODE_W         = 10;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0]        TRANSIENT_LIMIT_RESET = 8'h30;
    localparam logic [3:0]        LIMIT_CODE_RESET      = TRANSIENT_LIMIT_RESET[6:3];
    localparam logic [2:0]        LIMIT_EN_RESET        = TRANSIENT_LIMIT_RESET[2:0];
    localparam logic [1:0]        CODE_HI_RESET         = 2'h0;
    localparam logic [7:0]        CODE_LO_RESET         = 8'h00;
    localparam logic [CODE_W-1:0] CODE_MAX              = 10'h3ff;

    // Block state apart from the reset synchronizer, registered in one place
    typedef struct packed {
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
        logic [3:0]  limit_code;
        logic [2:0]  limit_en;
        logic [1:0]  code_hi;
        logic [7:0]  code_lo;
    } state_t;

endpackage

// ---- rtl/led_channel_current_regs.sv ----
/*
 * APB register bank holding the transient peak-current limit and the
 * first channel's 10-bit regulation current code.
 * Assumes APB signals come from logic on CLK; RSTN may be asynchronous.
 */
// The implementer's own choice: register access over APB.
// Behaviour
// - Four-bit peak limit code in transient register
// - One limit enable per channel switch
// - High register holds current code bits 9:8
// - Low register holds bits 7:0, reset zero
// - Any code up to 0x3ff is usable
// - Current code drives regulation monotonically
`timescale 1ns/1ns
`default_nettype none

module led_channel_current_regs
    import led_current_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RSTN,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    input  wire logic [3:0]        PSTRB,
    output var  logic [31:0]       PRDATA,
    output var  logic              PREADY,
    output var  logic              PSLVERR,
    output var  logic [3:0]        PEAK_LIMIT_CODE,
    output var  logic              FIRST_SWITCH_LIMIT_ENABLE,
    output var  logic              SECOND_SWITCH_LIMIT_ENABLE,
    output var  logic              THIRD_SWITCH_LIMIT_ENABLE,
    output var  logic [CODE_W-1:0] FIRST_CHANNEL_CURRENT_CODE
);

    // -------------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    // Async assert, sync release so no flop leaves reset mid-edge
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // -------------------------------------------------------------------
    // Bus decode and register next state
    // -------------------------------------------------------------------
    state_t state_reg;
    state_t state_next;
    logic   access;
    logic   do_write;
    logic   mapped;

    // One wait state: PREADY rises in the second access cycle
    always_comb begin
        state_next = state_reg;
        access     = PSEL && PENABLE;
        do_write   = access && state_reg.ready && PWRITE && PSTRB[0];
        mapped     = (PADDR == ADDR_TRANSIENT_LIMIT) || (PADDR == ADDR_CURRENT_HIGH)
                     || (PADDR == ADDR_CURRENT_LOW);
        state_next.ready  = access && !state_reg.ready;
        state_next.slverr = access && !state_reg.ready && !mapped;
        state_next.rdata  = 32'h0000_0000;
        // Read data captured a cycle early, unused bits stay zero
        if (access && !state_reg.ready && !PWRITE) begin
            case (PADDR)
                ADDR_TRANSIENT_LIMIT: begin
                    state_next.rdata[LIMIT_CODE_MSB:LIMIT_CODE_LSB] = state_reg.limit_code;
                    state_next.rdata[THIRD_EN_BIT:FIRST_EN_BIT]     = state_reg.limit_en;
                end
                ADDR_CURRENT_HIGH: begin
                    state_next.rdata[CODE_HI_MSB:0] = state_reg.code_hi;
                end
                ADDR_CURRENT_LOW: begin
                    state_next.rdata[7:0] = state_reg.code_lo;
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Writes land only at the edge where PREADY is sampled high
        if (do_write) begin
            case (PADDR)
                ADDR_TRANSIENT_LIMIT: begin
                    state_next.limit_code = PWDATA[LIMIT_CODE_MSB:LIMIT_CODE_LSB];
                    state_next.limit_en   = PWDATA[THIRD_EN_BIT:FIRST_EN_BIT];
                end
                ADDR_CURRENT_HIGH: begin
                    state_next.code_hi = PWDATA[CODE_HI_MSB:0];
                end
                ADDR_CURRENT_LOW: begin
                    state_next.code_lo = PWDATA[7:0];
                end
                default: begin
                    state_next.code_lo = state_reg.code_lo;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{ready: 1'b0, slverr: 1'b0, rdata: 32'h0000_0000,
                           limit_code: LIMIT_CODE_RESET, limit_en: LIMIT_EN_RESET,
                           code_hi: CODE_HI_RESET, code_lo: CODE_LO_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    // -------------------------------------------------------------------
    // Outputs, straight from the state flops
    // -------------------------------------------------------------------
    assign PRDATA                     = state_reg.rdata;
    assign PREADY                     = state_reg.ready;
    assign PSLVERR                    = state_reg.slverr;
    assign PEAK_LIMIT_CODE            = state_reg.limit_code;
    assign FIRST_SWITCH_LIMIT_ENABLE  = state_reg.limit_en[FIRST_EN_BIT];
    assign SECOND_SWITCH_LIMIT_ENABLE = state_reg.limit_en[SECOND_EN_BIT];
    assign THIRD_SWITCH_LIMIT_ENABLE  = state_reg.limit_en[THIRD_EN_BIT];
    // Plain binary code: higher code always means more current
    assign FIRST_CHANNEL_CURRENT_CODE = {state_reg.code_hi, state_reg.code_lo};

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    limit_code_write_a: assert property (
        (do_write && PADDR == ADDR_TRANSIENT_LIMIT) |=>
        PEAK_LIMIT_CODE == $past(PWDATA[LIMIT_CODE_MSB:LIMIT_CODE_LSB]))
        else $error("peak limit code not taken from write");
    limit_enable_write_a: assert property (
        (do_write && PADDR == ADDR_TRANSIENT_LIMIT) |=>
        {THIRD_SWITCH_LIMIT_ENABLE, SECOND_SWITCH_LIMIT_ENABLE, FIRST_SWITCH_LIMIT_ENABLE}
        == $past(PWDATA[THIRD_EN_BIT:FIRST_EN_BIT]))
        else $error("limit enables not taken from write");
    code_high_write_a: assert property (
        (do_write && PADDR == ADDR_CURRENT_HIGH) |=>
        FIRST_CHANNEL_CURRENT_CODE[9:8] == $past(PWDATA[1:0]) && $stable(FIRST_CHANNEL_CURRENT_CODE[7:0]))
        else $error("current code high bits wrong after write");
    code_low_write_a: assert property (
        (do_write && PADDR == ADDR_CURRENT_LOW) |=>
        FIRST_CHANNEL_CURRENT_CODE[7:0] == $past(PWDATA[7:0]) && $stable(FIRST_CHANNEL_CURRENT_CODE[9:8]))
        else $error("current code low bits wrong after write");
    code_hold_a: assert property (
        !do_write |=> $stable(FIRST_CHANNEL_CURRENT_CODE))
        else $error("current code changed without a write");
    code_readback_a: assert property (
        (PSEL && PENABLE && !PREADY && !PWRITE && PADDR == ADDR_CURRENT_LOW) ##1 PREADY |->
        PRDATA == {24'h000000, FIRST_CHANNEL_CURRENT_CODE[7:0]})
        else $error("low current register readback mismatch");
    unused_zero_a: assert property (
        (PSEL && PENABLE && !PREADY && !PWRITE && PADDR == ADDR_CURRENT_HIGH) |=>
        PREADY && PRDATA[31:2] == 30'h0)
        else $error("unused high register bits not zero");
    ready_one_cycle_a: assert property (
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    // -------------------------------------------------------------------
    // Bus response checks
    // -------------------------------------------------------------------
    // Error must never show without the completing ready beat
    slverr_with_ready_a: assert property (
        PSLVERR |-> PREADY)
        else $error("error flag without ready");
    unmapped_error_a: assert property (
        (PSEL && PENABLE && !PREADY && !mapped) |=> PREADY && PSLVERR)
        else $error("unmapped access not flagged");
    // Stale read data outside the ready beat would confuse a sloppy master
    idle_rdata_zero_a: assert property (
        !PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data not zero outside ready");
    limit_readback_a: assert property (
        (PSEL && PENABLE && !PREADY && !PWRITE && PADDR == ADDR_TRANSIENT_LIMIT) |=>
        PRDATA == {25'h0000000, PEAK_LIMIT_CODE, THIRD_SWITCH_LIMIT_ENABLE,
                   SECOND_SWITCH_LIMIT_ENABLE, FIRST_SWITCH_LIMIT_ENABLE})
        else $error("transient register readback mismatch");
    // Limit settings only move on a write to their own register
    limit_hold_a: assert property (
        !(do_write && PADDR == ADDR_TRANSIENT_LIMIT) |=>
        $stable(PEAK_LIMIT_CODE) && $stable(FIRST_SWITCH_LIMIT_ENABLE)
        && $stable(SECOND_SWITCH_LIMIT_ENABLE) && $stable(THIRD_SWITCH_LIMIT_ENABLE))
        else $error("limit settings changed without a write");
    // A write without the low byte strobe completes but stores nothing
    masked_write_a: assert property (
        (access && PREADY && PWRITE && !PSTRB[0]) |=>
        $stable(FIRST_CHANNEL_CURRENT_CODE) && $stable(PEAK_LIMIT_CODE))
        else $error("masked write changed a register");

    // -------------------------------------------------------------------
    // Coverage of the main scenarios
    // -------------------------------------------------------------------
    full_code_c: cover property (FIRST_CHANNEL_CURRENT_CODE == CODE_MAX);
    back_to_back_c: cover property (PREADY ##1 (PSEL && !PENABLE));
    all_limits_c: cover property (FIRST_SWITCH_LIMIT_ENABLE && SECOND_SWITCH_LIMIT_ENABLE
                                  && THIRD_SWITCH_LIMIT_ENABLE && PEAK_LIMIT_CODE == 4'hf);
    unmapped_c: cover property (PREADY && PSLVERR);

endmodule

`default_nettype wire

// ---- verif/led_channel_current_regs_test.sv ----
/*
 * Self-checking bench for the LED channel current register bank.
 * Assumes an APB slave with one wait state and byte-wide registers.
 */
`timescale 1ns/1ns
`default_nettype none

module led_channel_current_regs_test;
    import led_current_pkg::*;

    logic              CLK     = 1'b0;
    logic              RSTN    = 1'b0;
    logic              PSEL    = 1'b0;
    logic              PENABLE = 1'b0;
    logic              PWRITE  = 1'b0;
    logic [ADDR_W-1:0] PADDR   = '0;
    logic [31:0]       PWDATA  = '0;
    logic [3:0]        PSTRB   = '0;
    logic [31:0]       PRDATA;
    logic              PREADY, PSLVERR, EN1, EN2, EN3;
    logic [3:0]        PEAK_LIMIT_CODE;
    logic [CODE_W-1:0] CODE_OUT;
    logic [33:0]       exp_q[$];
    logic [33:0]       e;
    logic [31:0]       v;
    logic [9:0]        code = '0;
    logic [6:0]        lim;
    int                errors = 0, n_tests = 0, cycles = 0;

    led_channel_current_regs u_led_channel_current_regs (
        .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PEAK_LIMIT_CODE(PEAK_LIMIT_CODE),
        .FIRST_SWITCH_LIMIT_ENABLE(EN1), .SECOND_SWITCH_LIMIT_ENABLE(EN2),
        .THIRD_SWITCH_LIMIT_ENABLE(EN3), .FIRST_CHANNEL_CURRENT_CODE(CODE_OUT));

    // 25 MHz clock
    initial begin
        forever #20 CLK = ~CLK;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; expectation {is_read, slverr, rdata} queued first.
    // Request stays up after completion so a following setup is back to back.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [33:0] x);
        exp_q.push_back(x);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        PSTRB   <= s;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
    endtask

    task automatic idle();
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    function automatic logic [16:0] outs();
        return {PEAK_LIMIT_CODE, EN3, EN2, EN1, CODE_OUT};
    endfunction

    // Monitor: every completed transfer retires the oldest expectation
    always @(posedge CLK) begin
        if (PREADY === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3_ffff_ffff;
            check({e[33], PSLVERR, e[33] ? PRDATA : 32'h0}, e);
        end
    end

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        v = $urandom(95037);
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLK);
        check(outs(), {4'h6, 3'h0, 10'h000});
        apb(0, ADDR_TRANSIENT_LIMIT, 0, 4'hf, {2'b10, 32'h30});
        apb(0, ADDR_CURRENT_HIGH, 0, 4'hf, {2'b10, 32'h0});
        apb(0, ADDR_CURRENT_LOW, 0, 4'hf, {2'b10, 32'h0});
        idle();
        // Every limit code, enables rotating, junk in unused bits
        for (int i = 0; i < 16; i++) begin
            v = $urandom;
            v[7:0] = {1'b1, 4'(i), 3'(i * 5)};
            lim = v[6:0];
            apb(1, ADDR_TRANSIENT_LIMIT, v, 4'h1, 34'h0);
            apb(0, ADDR_TRANSIENT_LIMIT, 0, 4'hf, {2'b10, 25'h0, lim});
            idle();
            check(outs(), {lim, code});
        end
        // Current code: top, zero, then random codes
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            code = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : v[9:0];
            apb(1, ADDR_CURRENT_HIGH, {v[31:2], code[9:8]}, 4'h1, 34'h0);
            apb(1, ADDR_CURRENT_LOW, {v[31:8], code[7:0]}, 4'h1, 34'h0);
            apb(0, ADDR_CURRENT_HIGH, 0, 4'hf, {2'b10, 30'h0, code[9:8]});
            apb(0, ADDR_CURRENT_LOW, 0, 4'hf, {2'b10, 24'h0, code[7:0]});
            idle();
            check(outs(), {lim, code});
        end
        // Masked byte write and unmapped places leave everything alone
        apb(1, ADDR_CURRENT_LOW, ~{22'h0, code}, 4'he, 34'h0);
        apb(1, 8'h14, v, 4'hf, {2'b01, 32'h0});
        apb(0, 8'h00, 0, 4'hf, {2'b11, 32'h0});
        idle();
        check(outs(), {lim, code});
        repeat (2) @(posedge CLK);
        check(34'(exp_q.size()), 34'h0);
        end_sim();
    end

endmodule

`default_nettype wire
